// ### hdl/phy_regs_pkg.sv
// Register map, field positions and timing constants for the 10Base-T block
package phy_regs_pkg;
  localparam logic [4:0] tenbase_ops_addr = 5'h12;
  localparam logic [4:0] ext_ctrl_two_addr = 5'h13;
  // Operations register fields
  localparam int ops_rjab_bit = 15;
  localparam int ops_polrev_bit = 14;
  localparam int ops_jab_inh_bit = 5;
  localparam int ops_apol_inh_bit = 3;
  localparam int ops_sqe_inh_bit = 2;
  localparam int ops_link_inh_bit = 1;
  localparam int ops_sq_inh_bit = 0;
  localparam logic [15:0] ops_rw_mask = 16'h3fff;
  localparam logic [15:0] ops_reset = 16'h0010;
  // Extended control two fields
  localparam int ext_node_bit = 15;
  localparam int ext_hwsw_bit = 14;
  localparam int ext_rfault_bit = 13;
  localparam int ext_xauto_bit = 9;
  localparam int ext_swap_bit = 8;
  localparam int ext_hiz_bit = 7;
  localparam int ext_apd_bit = 0;
  localparam logic [15:0] ext_rw_mask = 16'h1bff;
  localparam logic [15:0] ext_reset = 16'h4201;
  // Timing: jabber limit 20 ms, quality-test pulse 1 us
  localparam int jabber_ms = 20;
  localparam int clk_khz = 10000;
  localparam int jabber_cycles = jabber_ms * clk_khz;
  localparam int sqe_ns = 1000;
  localparam int clk_ns = 100;
  localparam int sqe_cycles = (sqe_ns + clk_ns - 1) / clk_ns;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mgmt_req_t;

  typedef struct packed {
    logic jab_inh;
    logic apol_inh;
    logic sqe_inh;
    logic link_inh;
    logic sq_inh;
  } ops_ctrl_t;
endpackage

// ### hdl/phy_tenbase_ops_ext_ctrl_regs.sv
// 10Base-T operations and extended control two registers with their control
`timescale 1ns/1ns
// Overview of operation
// R1 - Remote jabber flag latches high, read of operations register clears it
// R2 - Receive activity timed with transmit jabber limit; flag informs only
// R3 - Polarity bit shows reversed receive pair, operation continues
// R4 - Jabber inhibit zero enables transmit jabber check, one disables
// R5 - Auto polarity inhibit zero corrects reversed pair, one does not
// R6 - Polarity correction still works with automatic crossover off
// R7 - Quality-test inhibit zero generates test pulse, one suppresses it
// R8 - Quality-test pulse drives collision after transmit enable falls
// R9 - Full duplex or repeater suppresses test; inhibit bit unchanged
// R10 - Link loss inhibit forces link passed, else follows receive
// R11 - Squelch inhibit one needs data then idle before link
// R12 - Management writes reserved bits with their defaults
// R13 - Node/repeater bit reads zero, hardware/software bit reads one
// R14 - Tri-state bit resets zero; one puts transmit pair high impedance
// R15 - Auto power-down resets one; zero stops automatic shutdown
// R16 - Carrier sense asserts on transmit or receive activity
// R17 - Quality test enabled by default in node operation
// R18 - Crossover enable zero forces pair by swap bit, else auto while crossover_auto_enable is high, straight while it is low
// R19 - Power-down bit one in 10Base-T mode switches off 100Base-TX
// R20 - Event coinciding with clearing read stays set
module phy_tenbase_ops_ext_ctrl_regs
  import phy_regs_pkg::*;
#(
  parameter int jabber_limit = jabber_cycles,
  parameter int sqe_len = sqe_cycles
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Management register port
  input wire mgmt_req_t mreq,
  output logic [15:0] rdata,
  // Line status from receive path
  input wire logic rx_activity,
  input wire logic rx_pair_pos,
  input wire logic rx_pair_neg,
  input wire logic rx_valid_data,
  input wire logic rx_idle,
  input wire logic remote_fault,
  // MAC side and mode
  input wire logic tx_en,
  input wire logic full_duplex,
  input wire logic ten_mode,
  input wire logic crossover_auto_enable,
  input wire logic auto_mdix_choice,
  // Controls out
  output logic col,
  output logic crs,
  output logic link_pass,
  output logic tx_jabber,
  output logic pol_correct,
  output logic pair_cross,
  output logic twisted_pair_hiz,
  output logic tx100_power_off
);
  // Pulse counter is eight bits wide
  if (jabber_limit < 2 || sqe_len < 1 || sqe_len > 255)
  begin : g_bad_timing
    $error("bad timing parameter");
  end

  localparam logic node_repeater_select = 1'b0;
  localparam int jw = $clog2(jabber_limit + 1);

  logic [15:0] ops_r, ext_r;
  logic rx_lvl, pol_lvl, pol_sticky, rjab_sticky, xauto_lvl;
  logic jab_evt, ops_read;
  logic [jw-1:0] rxcnt_r, txcnt_r;
  logic [7:0] sqe_r;
  logic tx_d_r, jab_r, link_r, seen_data_r;
  logic rxd_s, rxi_s, pn_lvl, pp_s;
  ops_ctrl_t ctl;

  assign ctl = ops_ctrl_t'({ops_r[ops_jab_inh_bit], ops_r[ops_apol_inh_bit],
    ops_r[ops_sqe_inh_bit], ops_r[ops_link_inh_bit], ops_r[ops_sq_inh_bit]});
  assign ops_read = mreq.rd && (mreq.addr == tenbase_ops_addr);
  wire ops_write = mreq.wr && (mreq.addr == tenbase_ops_addr);
  wire ext_write = mreq.wr && (mreq.addr == ext_ctrl_two_addr);

  // Receive pair lines synced apart before they are combined
  sync_latch u_pp (.clk_sys(clk_sys), .rst(rst), .async_in(rx_pair_pos),
    .clr(1'b0), .level(pp_s), .sticky());
  sync_latch u_pn (.clk_sys(clk_sys), .rst(rst), .async_in(rx_pair_neg),
    .clr(1'b0), .level(pn_lvl), .sticky());
  // Reversed pair: negative line seen active while positive idle
  wire pol_raw = pn_lvl & ~pp_s;
  // Receive jabber on line is an async event
  sync_latch u_rx (.clk_sys(clk_sys), .rst(rst), .async_in(rx_activity),
    .clr(1'b0), .level(rx_lvl), .sticky());
  sync_latch u_pol (.clk_sys(clk_sys), .rst(rst), .async_in(pol_raw),
    .clr(ops_read), .level(pol_lvl), .sticky(pol_sticky)); // R3
  sync_latch u_xa (.clk_sys(clk_sys), .rst(rst),
    .async_in(crossover_auto_enable), .clr(1'b0), .level(xauto_lvl),
    .sticky());
  sync_latch u_dat (.clk_sys(clk_sys), .rst(rst), .async_in(rx_valid_data),
    .clr(1'b0), .level(rxd_s), .sticky());
  sync_latch u_idl (.clk_sys(clk_sys), .rst(rst), .async_in(rx_idle),
    .clr(1'b0), .level(rxi_s), .sticky());

  assign jab_evt = (rxcnt_r == jw'(jabber_limit)) && rx_lvl; // R2

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rxcnt_r <= '0;
    else if (!rx_lvl)
      rxcnt_r <= '0;
    else if (rxcnt_r != jw'(jabber_limit))
      rxcnt_r <= rxcnt_r + 1'b1; // R2
  end

  // Remote jabber sticky, set beats clear
  logic rjab_r;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rjab_r <= 1'b0;
    else
      rjab_r <= jab_evt | (rjab_r & ~ops_read); // R1 R20
  end
  assign rjab_sticky = rjab_r;

  // Register writes; reserved bits kept as written by the manager, except extended control two bit 10, stored as zero
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ops_r <= ops_reset; // R17
      ext_r <= ext_reset; // R14 R15
    end
    else
    begin
      if (ops_write)
        ops_r <= mreq.wdata & ops_rw_mask; // R12
      if (ext_write)
        ext_r <= mreq.wdata & ext_rw_mask; // R12
    end
  end

  // Read data, registered
  wire [15:0] ops_view = {rjab_sticky, pol_sticky | pol_lvl,
    ops_r[13:0]}; // R1 R3
  wire [15:0] ext_view = {node_repeater_select, 1'b1, remote_fault,
    ext_r[12:0]}; // R13
  wire [15:0] rd_mux = (mreq.addr == tenbase_ops_addr) ? ops_view :
    (mreq.addr == ext_ctrl_two_addr) ? ext_view : 16'h0000;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata <= 16'h0000;
    else if (mreq.rd)
      rdata <= rd_mux;
  end

  // Transmit jabber check
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      txcnt_r <= '0;
      jab_r <= 1'b0;
    end
    else if (!tx_en || ctl.jab_inh)
    begin
      txcnt_r <= '0;
      jab_r <= 1'b0; // R4
    end
    else if (txcnt_r != jw'(jabber_limit))
      txcnt_r <= txcnt_r + 1'b1;
    else
      jab_r <= 1'b1; // R4
  end
  assign tx_jabber = jab_r;

  // Quality test pulse after transmit ends
  wire sqe_allow = !ctl.sqe_inh && !full_duplex && !node_repeater_select;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tx_d_r <= 1'b0;
      sqe_r <= 8'h00;
    end
    else
    begin
      tx_d_r <= tx_en;
      if (tx_d_r && !tx_en && sqe_allow)
        sqe_r <= 8'(sqe_len); // R7 R8 R9
      else if (sqe_r != 8'h00)
        sqe_r <= sqe_r - 8'h01;
    end
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      col <= 1'b0;
    else
      col <= (sqe_r != 8'h00); // R8
  end

  // Link integrity and squelch qualification
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      seen_data_r <= 1'b0;
      link_r <= 1'b0;
    end
    else if (ctl.link_inh)
      link_r <= 1'b1; // R10
    else if (!rx_lvl && !rxd_s && !rxi_s)
    begin
      link_r <= 1'b0; // R10
      seen_data_r <= 1'b0;
    end
    else if (rxd_s)
    begin
      seen_data_r <= 1'b1;
      if (!ctl.sq_inh)
        link_r <= 1'b1; // R11
    end
    else if (rxi_s && seen_data_r)
      link_r <= 1'b1; // R11
  end
  assign link_pass = link_r;

  // Registered control outputs
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      crs <= 1'b0;
      pol_correct <= 1'b0;
      pair_cross <= 1'b0;
      twisted_pair_hiz <= 1'b0;
      tx100_power_off <= 1'b0;
    end
    else
    begin
      crs <= tx_en | rx_lvl; // R16
      pol_correct <= pol_lvl & ~ctl.apol_inh; // R5 R6
      if (!ext_r[ext_xauto_bit])
        pair_cross <= ext_r[ext_swap_bit]; // R18
      else if (!xauto_lvl)
        pair_cross <= 1'b0; // R18
      else
        pair_cross <= auto_mdix_choice;
      twisted_pair_hiz <= ext_r[ext_hiz_bit]; // R14
      tx100_power_off <= ext_r[ext_apd_bit] & ten_mode; // R15 R19
    end
  end

  property p_rjab_clear;
    @(posedge clk_sys) disable iff (rst)
    ops_read && !jab_evt |=> !rjab_r;
  endproperty
  a_rjab_clear: assert property (p_rjab_clear) else $error("jab clr"); // R1

  property p_rjab_hold;
    @(posedge clk_sys) disable iff (rst)
    jab_evt |=> rjab_r;
  endproperty
  a_rjab_hold: assert property (p_rjab_hold) else $error("jab lost"); // R20

  property p_hiz;
    @(posedge clk_sys) disable iff (rst)
    ext_write |-> ##2 twisted_pair_hiz == $past(mreq.wdata[ext_hiz_bit], 2);
  endproperty
  a_hiz: assert property (p_hiz) else $error("hiz"); // R14

  sequence s_tx_end;
    tx_d_r && !tx_en && sqe_allow;
  endsequence
  property p_sqe;
    @(posedge clk_sys) disable iff (rst)
    s_tx_end |=> ##1 col;
  endproperty
  a_sqe: assert property (p_sqe) else $error("sqe missing"); // R8

  property p_sqe_inh;
    @(posedge clk_sys) disable iff (rst)
    (ctl.sqe_inh || full_duplex) && sqe_r == 8'h00 |=> sqe_r == 8'h00;
  endproperty
  a_sqe_inh: assert property (p_sqe_inh) else $error("sqe inh"); // R9

  property p_link;
    @(posedge clk_sys) disable iff (rst)
    ctl.link_inh |=> link_pass;
  endproperty
  a_link: assert property (p_link) else $error("link"); // R10

  property p_crs;
    @(posedge clk_sys) disable iff (rst)
    tx_en |=> crs;
  endproperty
  a_crs: assert property (p_crs) else $error("crs"); // R16

  property p_jab_inh;
    @(posedge clk_sys) disable iff (rst)
    ctl.jab_inh |=> !tx_jabber;
  endproperty
  a_jab_inh: assert property (p_jab_inh) else $error("jab inh"); // R4

  property p_ro;
    @(posedge clk_sys) disable iff (rst)
    mreq.rd && mreq.addr == ext_ctrl_two_addr |=> rdata[15:14] == 2'b01;
  endproperty
  a_ro: assert property (p_ro) else $error("ro bits"); // R13
endmodule // phy_tenbase_ops_ext_ctrl_regs

// ### hdl/sync_latch.sv
// Two-stage synchroniser followed by a set-wins sticky latch
`timescale 1ns/1ns
module sync_latch
  import phy_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Event in and clear
  input wire logic async_in,
  input wire logic clr,
  // Outputs
  output logic level,
  output logic sticky
);
  logic s1_r, s2_r, sticky_r;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      sticky_r <= 1'b0;
    end
    else
    begin
      s1_r <= async_in;
      s2_r <= s1_r;
      sticky_r <= s2_r | (sticky_r & ~clr);
    end
  end
  assign level = s2_r;
  assign sticky = sticky_r;
endmodule // sync_latch

// ### testbench/mgmt_sta.sv
// Management station model driving the register port
`timescale 1ns/1ns
module mgmt_sta
  import phy_regs_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Register port
  output mgmt_req_t mreq,
  input wire logic [15:0] rdata
);
  initial mreq = '0;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = (a == tenbase_ops_addr) ? ((d & 16'hc02f) | 16'h0010)
      : (d & 16'he381);
    @(posedge clk_sys);
    mreq <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(posedge clk_sys);
    mreq.wr <= 1'b0;
    mreq.wdata <= ~v;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    mreq <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: mreq.wdata};
    @(posedge clk_sys);
    mreq.rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule // mgmt_sta

// ### testbench/phy_tenbase_ops_ext_ctrl_regs_tb.sv
// Self-checking bench for the 10Base-T register block
`timescale 1ns/1ns
module phy_tenbase_ops_ext_ctrl_regs_tb;
  import phy_regs_pkg::*;
  localparam int col_b = 7, crs_b = 6, link_b = 5, jab_b = 4, pol_b = 3;
  localparam int cross_b = 2, hiz_b = 1, pwr_b = 0;
  localparam logic [4:0] ops = tenbase_ops_addr, ext = ext_ctrl_two_addr;
  logic clk_sys = 0, rst = 1, rx_activity = 0, rx_pair_pos = 1;
  logic rx_pair_neg = 0, rx_valid_data = 0, rx_idle = 0, remote_fault = 0;
  logic tx_en = 0, full_duplex = 0, ten_mode = 1, crossover_auto_enable = 1;
  logic auto_mdix_choice = 0, col, crs, link_pass, tx_jabber, pol_correct;
  logic pair_cross, twisted_pair_hiz, tx100_power_off;
  logic [15:0] rdata, d, v;
  logic [7:0] outs;
  mgmt_req_t mreq;
  int err_total = 0, cmp_count = 0, seed = 32'hd697, k;
  assign outs = {col, crs, link_pass, tx_jabber, pol_correct, pair_cross,
    twisted_pair_hiz, tx100_power_off};
  always #50 clk_sys = ~clk_sys;
  mgmt_sta mgmt_sta_i (.clk_sys(clk_sys), .mreq(mreq), .rdata(rdata));
  phy_tenbase_ops_ext_ctrl_regs #(.jabber_limit(8), .sqe_len(sqe_cycles))
  phy_tenbase_ops_ext_ctrl_regs_i (.clk_sys(clk_sys), .rst(rst),
    .mreq(mreq), .rdata(rdata), .rx_activity(rx_activity),
    .rx_pair_pos(rx_pair_pos), .rx_pair_neg(rx_pair_neg),
    .rx_valid_data(rx_valid_data), .rx_idle(rx_idle),
    .remote_fault(remote_fault), .tx_en(tx_en), .full_duplex(full_duplex),
    .ten_mode(ten_mode), .crossover_auto_enable(crossover_auto_enable),
    .auto_mdix_choice(auto_mdix_choice), .col(col), .crs(crs),
    .link_pass(link_pass), .tx_jabber(tx_jabber), .pol_correct(pol_correct),
    .pair_cross(pair_cross), .twisted_pair_hiz(twisted_pair_hiz),
    .tx100_power_off(tx100_power_off));
  function automatic logic [15:0] exp_ops(input logic [15:0] w);
    return (w & 16'h002f) | 16'h0010;
  endfunction
  function automatic logic [15:0] exp_ext(input logic [15:0] w);
    return (w & 16'h2381) | 16'h4000;
  endfunction
  task automatic conclude();
    $display("mismatches %0d of %0d checks", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic bad(input logic [15:0] g, input logic [15:0] e);
    err_total++;
    $display("BAD t=%0t got=%h exp=%h", $time, g, e);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] e, m);
    mgmt_sta_i.rd(a, d);
    cmp_count++;
    if ((d & m) !== (e & m))
      bad(d, e);
  endtask
  task automatic wait_out(input int i, input logic val, input int lim);
    cmp_count++;
    repeat (lim)
    begin
      @(posedge clk_sys);
      #1;
      if (outs[i] === val)
        return;
    end
    bad(16'(outs), 16'(val));
    conclude();
  endtask
  task automatic hold_out(input int i, input logic val, input int cyc);
    cmp_count++;
    repeat (cyc)
    begin
      @(posedge clk_sys);
      #1;
      if (outs[i] !== val)
        k = -1;
    end
    if (k == -1)
      bad(16'(outs), 16'(val));
    k = 0;
  endtask
  task automatic tx(input logic val);
    @(posedge clk_sys);
    tx_en <= val;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 0;
    rchk(ops, ops_reset, 16'hbfff);
    rchk(ext, 16'h4201, 16'hffff);
    wait_out(hiz_b, 0, 3);
    wait_out(pwr_b, 1, 3);
    hold_out(link_b, 0, 5);
    rchk(5'h1f, 16'h0000, 16'hffff);
    repeat (8)
    begin
      v = $random(seed);
      remote_fault <= v[13];
      mgmt_sta_i.wr(ops, v);
      rchk(ops, exp_ops(v), 16'hbfff);
      mgmt_sta_i.wr(ext, v);
      mgmt_sta_i.wr(5'h11, ~v);
      rchk(ext, exp_ext(v), 16'hffff);
    end
    for (int i = 0; i < 4; i++)
    begin
      mgmt_sta_i.wr(ext, {7'h00, i[0], i[1], 6'h00, i[0]});
      wait_out(cross_b, i[0], 5);
      wait_out(hiz_b, i[1], 5);
      wait_out(pwr_b, i[0], 5);
    end
    ten_mode <= 0;
    wait_out(pwr_b, 0, 5);
    mgmt_sta_i.wr(ext, 16'h0200);
    auto_mdix_choice <= 1;
    wait_out(cross_b, 1, 8);
    crossover_auto_enable <= 0;
    wait_out(cross_b, 0, 6);
    hold_out(cross_b, 0, 6);
    mgmt_sta_i.wr(ops, 16'h0010);
    tx(1);
    wait_out(crs_b, 1, 4);
    wait_out(jab_b, 1, 40);
    tx(0);
    wait_out(col_b, 1, 20);
    do
    begin
      k++;
      @(posedge clk_sys);
      #1;
    end while (col === 1'b1 && k < 50);
    cmp_count++;
    if (k != sqe_cycles)
      bad(16'(k), 16'(sqe_cycles));
    k = 0;
    rx_activity <= 1;
    wait_out(crs_b, 1, 6);
    hold_out(jab_b, 0, 30);
    rx_activity <= 0;
    repeat (3) @(posedge clk_sys);
    rchk(ops, 16'h8000, 16'h8000);
    rchk(ops, 16'h0000, 16'h8000);
    mgmt_sta_i.wr(ops, 16'h0024);
    tx(1);
    hold_out(jab_b, 0, 30);
    tx(0);
    hold_out(col_b, 0, 20);
    mgmt_sta_i.wr(ops, 16'h0010);
    full_duplex <= 1;
    tx(1);
    tx(0);
    hold_out(col_b, 0, 20);
    rchk(ops, 16'h0010, 16'h003f);
    mgmt_sta_i.wr(ops, 16'h0012);
    wait_out(link_b, 1, 6);
    mgmt_sta_i.wr(ops, 16'h0011);
    wait_out(link_b, 0, 20);
    rx_valid_data <= 1;
    hold_out(link_b, 0, 6);
    rx_valid_data <= 0;
    rx_idle <= 1;
    wait_out(link_b, 1, 8);
    rx_idle <= 0;
    mgmt_sta_i.wr(ops, 16'h0010);
    wait_out(link_b, 0, 20);
    rx_valid_data <= 1;
    wait_out(link_b, 1, 8);
    rx_pair_pos <= 0;
    rx_pair_neg <= 1;
    wait_out(pol_b, 1, 8);
    rchk(ops, 16'h4000, 16'h4000);
    mgmt_sta_i.wr(ops, 16'h0018);
    wait_out(pol_b, 0, 8);
    conclude();
  end
endmodule // phy_tenbase_ops_ext_ctrl_regs_tb
